/* File: rtl/lffr_pulse.v */
`timescale 1ns/100ps
`default_nettype none
module lffr_pulse #(
   parameter [12:0] CYC = 13'h1388
) (
   input  wire clk,
   input  wire rst,
   input  wire trig,
   output wire busy
);
   reg [12:0] cnt_q;

   // A new trigger during a pulse restarts the full length.
   always @(posedge clk or posedge rst)
   begin
      if (rst)
         cnt_q <= 13'h0;
      else if (trig)
         cnt_q <= CYC;
      else if (cnt_q != 13'h0)
         cnt_q <= cnt_q - 13'h1;
   end

   assign busy = (cnt_q != 13'h0);
endmodule
`default_nettype wire

/* File: rtl/lffr_regs.vh */
`ifndef LFFR_REGS_VH
`define LFFR_REGS_VH

`define LFFR_CLK_MHZ       100
`define LFFR_PULSE_US      50
`define LFFR_PULSE_CYC     (`LFFR_PULSE_US * `LFFR_CLK_MHZ)
`define LFFR_WDT_STEP_US   1000
`define LFFR_WDT_STEP_CYC  (`LFFR_WDT_STEP_US * `LFFR_CLK_MHZ)
`define LFFR_OPEN_DEG_US   5
`define LFFR_OPEN_DEG_CYC  (`LFFR_OPEN_DEG_US * `LFFR_CLK_MHZ)
`define LFFR_SHORT_DEG_US  2
`define LFFR_SHORT_DEG_CYC (`LFFR_SHORT_DEG_US * `LFFR_CLK_MHZ)
`define LFFR_SLS_DEG_US    5
`define LFFR_SLS_DEG_CYC   (`LFFR_SLS_DEG_US * `LFFR_CLK_MHZ)

`define LFFR_A_CTRL        8'h00
`define LFFR_A_STATUS      8'h04
`define LFFR_A_MASK        8'h08
`define LFFR_A_CHEN        8'h0c
`define LFFR_A_DIAGEN      8'h10
`define LFFR_A_OPEN        8'h14
`define LFFR_A_SHORT       8'h18
`define LFFR_A_SLS         8'h1c
`define LFFR_A_STATE       8'h20
`define LFFR_A_CRC         8'h24

`define LFFR_CTRL_CLR      0
`define LFFR_CTRL_FSCLR    1
`define LFFR_CTRL_PORCLR   2
`define LFFR_CTRL_SINGLE_SHORT_ENABLE    3
`define LFFR_CTRL_WDT_LSB  4
`define LFFR_CTRL_BLK_LSB  8

`define LFFR_ST_LOWSUP     0
`define LFFR_ST_SUPUV      1
`define LFFR_ST_REF        2
`define LFFR_ST_PRETH      3
`define LFFR_ST_THERM      4
`define LFFR_ST_CRC        5
`define LFFR_ST_OUT        6
`define LFFR_ST_GLOBAL     7
`define LFFR_ST_POR        8
`define LFFR_ST_FS         9

`define LFFR_MK_OPEN       6
`define LFFR_MK_SHORT      7
`define LFFR_MK_SLS        8

`define LFFR_RST_BLANK     8'h10
`define LFFR_RST_WDT       4'h0
`define LFFR_RST_DIAGEN    24'hffffff
`define LFFR_RST_CRC       8'hff

`define LFFR_S_POR         2'h0
`define LFFR_S_INIT        2'h1
`define LFFR_S_NORMAL      2'h2
`define LFFR_S_FAILSAFE    2'h3

`endif

/* File: rtl/lffr_sync.v */
`timescale 1ns/100ps
`default_nettype none
module lffr_sync #(
   parameter W = 1
) (
   input  wire         clk,
   input  wire         rst,
   input  wire [W-1:0] d,
   output wire [W-1:0] q
);
   reg [W-1:0] meta_q;
   reg [W-1:0] sync_q;

   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         meta_q <= {W{1'b0}};
         sync_q <= {W{1'b0}};
      end
      else
      begin
         meta_q <= d;
         sync_q <= meta_q;
      end
   end

   assign q = sync_q;
endmodule
`default_nettype wire

/* File: rtl/lffr_top.v */
// How it works
// - open-load mask keeps fault off global reporting
// - short mask keeps fault off global reporting
// - unmasked single-short sets its channel flag and the output flag, pulses pin
// - rail fault enters restart, holds pin low
// - low supply blocks open-load and single-short detections, latches, pulses
// - undervoltage cuts outputs, holds pin low
// - reference fault holds pin low, auto release
// - thermal cuts outputs, holds pin, resumes
// - pre-thermal latches flag, pulses pin once
// - open-load needs enables, supply, long pulse
// - short needs enables and long pulse
// - single-short also needs its global enable
// - CRC mismatch latches flag, maskable pulse
// - watchdog overflow enters fail-safe; clear returns
// - fault-clear bit clears all but power-on and fail-safe flags, self-returns
// - watchdog restarts on good transfer, counts idle
// - setting zero disables, fifteen forces fail-safe
//
// Strobed register access and the address map were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "lffr_regs.vh"
module lffr_top #(
   parameter [12:0] PULSE_CYC    = `LFFR_PULSE_CYC,
   parameter [16:0] WDT_STEP_CYC = `LFFR_WDT_STEP_CYC
) (
   input  wire        CORE_CLK,
   input  wire        RST,
   input  wire [7:0]  ADDR,
   input  wire [31:0] WDATA,
   input  wire        WR,
   input  wire        RD,
   output wire [31:0] RDATA,
   output wire        IRQ,
   input  wire [23:0] CHAN_OPEN_DET,
   input  wire [23:0] CHAN_SHORT_DET,
   input  wire [23:0] CHAN_SLS_DET,
   input  wire [23:0] PWM_ON,
   input  wire        LOW_SUPPLY_DET,
   input  wire        SUPPLY_UV_DET,
   input  wire        REF_FAULT_DET,
   input  wire        PRETHERMAL_DET,
   input  wire        THERMAL_DET,
   input  wire        RAIL_FAULT_DET,
   input  wire [7:0]  COMPUTED_CONFIG_CRC,
   input  wire        CRC_CHECK_DONE,
   input  wire        BUS_IDLE,
   input  wire        XFER_OK,
   input  wire        FAULT_PIN_I,
   output wire        FAULT_PIN_O,
   output wire        FAULT_PIN_OE_N,
   output wire        OUTPUTS_OFF,
   output wire        DETECT_HOLD,
   output wire [23:0] CHAN_OUT_EN,
   output wire [1:0]  DEV_STATE
);
   localparam [10:0] OPEN_DEG  = `LFFR_OPEN_DEG_CYC;
   localparam [10:0] SHORT_DEG = `LFFR_SHORT_DEG_CYC;
   localparam [10:0] SLS_DEG   = `LFFR_SLS_DEG_CYC;

   // True once the on-time has passed blanking plus the deglitch time.
   function qual;
      input [10:0] cnt;
      input [7:0]  blank;
      input [10:0] deg;
      begin
         qual = ({1'b0, cnt} >= ({4'h0, blank} + {1'b0, deg}));
      end
   endfunction

   wire [78:0] sync_out;
   wire [23:0] open_s;
   wire [23:0] short_s;
   wire [23:0] sls_s;
   wire        lowsup_s;
   wire        supuv_s;
   wire        ref_s;
   wire        preth_s;
   wire        therm_s;
   wire        rail_s;
   wire        pin_s;

   lffr_sync #(
      .W (79)
   ) u_sync (
      .clk (CORE_CLK),
      .rst (RST),
      .d   ({FAULT_PIN_I, RAIL_FAULT_DET, THERMAL_DET, PRETHERMAL_DET,
             REF_FAULT_DET, SUPPLY_UV_DET, LOW_SUPPLY_DET,
             CHAN_SLS_DET, CHAN_SHORT_DET, CHAN_OPEN_DET}),
      .q   (sync_out)
   );

   assign open_s   = sync_out[23:0];
   assign short_s  = sync_out[47:24];
   assign sls_s    = sync_out[71:48];
   assign lowsup_s = sync_out[72];
   assign supuv_s  = sync_out[73];
   assign ref_s    = sync_out[74];
   assign preth_s  = sync_out[75];
   assign therm_s  = sync_out[76];
   assign rail_s   = sync_out[77];
   assign pin_s    = sync_out[78];

   reg        clr_q;
   reg        fs_clr_q;
   reg        por_clr_q;
   reg        sls_en_q;
   reg [3:0]  wdt_set_q;
   reg [7:0]  blank_q;
   reg [8:0]  mask_q;
   reg [23:0] chen_q;
   reg [23:0] diag_q;
   reg [7:0]  crc_q;
   reg [5:0]  st_q;
   reg        out_q;
   reg        por_q;
   reg        fs_q;
   reg [23:0] open_q;
   reg [23:0] short_q;
   reg [23:0] sls_q;
   reg [1:0]  state_q;
   reg [1:0]  state_d;
   reg [16:0] wdt_pre_q;
   reg [3:0]  wdt_step_q;
   reg [31:0] rdata_q;
   reg [10:0] pwm_cnt_q [0:23];
   reg [23:0] open_det;
   reg [23:0] short_det;
   reg [23:0] sls_det;
   integer    i;

   wire wr_ctrl   = WR && (ADDR == `LFFR_A_CTRL);
   wire wr_status = WR && (ADDR == `LFFR_A_STATUS);
   wire running   = (state_q == `LFFR_S_NORMAL) || (state_q == `LFFR_S_FAILSAFE);

   // Low supply lifts itself: open-load and single-short detection is blocked only while it lasts.
   assign DETECT_HOLD = lowsup_s;

   always @*
   begin
      for (i = 0; i < 24; i = i + 1)
      begin
         open_det[i] = running && open_s[i] && chen_q[i] && diag_q[i] && !lowsup_s
                       && PWM_ON[i] && qual(pwm_cnt_q[i], blank_q, OPEN_DEG);
         short_det[i] = running && short_s[i] && chen_q[i] && diag_q[i]
                        && PWM_ON[i] && qual(pwm_cnt_q[i], blank_q, SHORT_DEG);
         sls_det[i] = running && sls_s[i] && chen_q[i] && diag_q[i] && sls_en_q
                      && !lowsup_s && PWM_ON[i]
                      && qual(pwm_cnt_q[i], blank_q, SLS_DEG);
      end
   end

   // On-time counters measure how long each channel's PWM has been on.
   always @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
      begin
         for (i = 0; i < 24; i = i + 1)
            pwm_cnt_q[i] <= 11'h0;
      end
      else
      begin
         for (i = 0; i < 24; i = i + 1)
         begin
            if (!PWM_ON[i])
               pwm_cnt_q[i] <= 11'h0;
            else if (pwm_cnt_q[i] != 11'h7ff)
               pwm_cnt_q[i] <= pwm_cnt_q[i] + 11'h1;
         end
      end
   end

   wire [5:0] st_set;
   assign st_set[`LFFR_ST_LOWSUP] = running && lowsup_s;
   assign st_set[`LFFR_ST_SUPUV]  = running && supuv_s;
   assign st_set[`LFFR_ST_REF]    = running && ref_s;
   assign st_set[`LFFR_ST_PRETH]  = running && preth_s;
   assign st_set[`LFFR_ST_THERM]  = running && therm_s;
   assign st_set[`LFFR_ST_CRC]    = running && CRC_CHECK_DONE
                                    && (COMPUTED_CONFIG_CRC != crc_q);

   wire open_um  = !mask_q[`LFFR_MK_OPEN];
   wire short_um = !mask_q[`LFFR_MK_SHORT];
   wire sls_um   = !mask_q[`LFFR_MK_SLS];
   wire out_set  = (|open_det && open_um) || (|short_det && short_um)
                   || (|sls_det && sls_um);

   wire [5:0] st_new  = st_set & ~st_q & ~mask_q[5:0];
   wire       chan_new = (|(open_det & ~open_q) && open_um)
                         || (|(short_det & ~short_q) && short_um)
                         || (|(sls_det & ~sls_q) && sls_um);
   wire       pulse_trig = st_new[`LFFR_ST_LOWSUP] || st_new[`LFFR_ST_PRETH]
                           || st_new[`LFFR_ST_CRC] || chan_new;
   wire       pulse_busy;

   lffr_pulse #(
      .CYC (PULSE_CYC)
   ) u_pulse (
      .clk  (CORE_CLK),
      .rst  (RST),
      .trig (pulse_trig),
      .busy (pulse_busy)
   );

   wire const_pull = (state_q == `LFFR_S_POR)
                     || (supuv_s && !mask_q[`LFFR_ST_SUPUV])
                     || (ref_s && !mask_q[`LFFR_ST_REF])
                     || (therm_s && !mask_q[`LFFR_ST_THERM]);

   // The pin only ever sinks; the constant pull covers any pulse.
   assign FAULT_PIN_O    = 1'b0;
   assign FAULT_PIN_OE_N = !(const_pull || pulse_busy);

   wire gflag = out_q || (|(st_q & ~mask_q[5:0])) || por_q;
   assign IRQ = gflag;

   assign OUTPUTS_OFF = supuv_s || therm_s || !running;
   assign CHAN_OUT_EN = OUTPUTS_OFF ? 24'h0 : chen_q;
   assign DEV_STATE   = state_q;

   // Flags: hardware set wins over a clear in the same cycle.
   always @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
      begin
         st_q    <= 6'h0;
         out_q   <= 1'b0;
         open_q  <= 24'h0;
         short_q <= 24'h0;
         sls_q   <= 24'h0;
         por_q   <= 1'b0;
         fs_q    <= 1'b0;
      end
      else
      begin
         st_q <= (st_q & ~({6{clr_q}} | (wr_status ? WDATA[5:0] : 6'h0)))
                 | st_set;
         out_q <= (out_q && !clr_q && !(wr_status && WDATA[`LFFR_ST_OUT]))
                  || out_set;
         open_q  <= (open_q & ~{24{clr_q}}) | open_det;
         short_q <= (short_q & ~{24{clr_q}}) | short_det;
         sls_q   <= (sls_q & ~{24{clr_q}}) | sls_det;
         por_q   <= (por_q && !por_clr_q) || (state_q == `LFFR_S_POR);
         fs_q    <= (fs_q && !fs_clr_q) || (state_d == `LFFR_S_FAILSAFE
                                            && state_q == `LFFR_S_NORMAL);
      end
   end

   // Watchdog: a prescaler of fixed length times each step of the setting.
   wire wdt_ovf = (state_q == `LFFR_S_NORMAL)
                  && ((wdt_set_q == 4'hf)
                      || (wdt_set_q != 4'h0 && wdt_step_q == wdt_set_q));

   always @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
      begin
         wdt_pre_q  <= 17'h0;
         wdt_step_q <= 4'h0;
      end
      else if (XFER_OK || state_q != `LFFR_S_NORMAL)
      begin
         wdt_pre_q  <= 17'h0;
         wdt_step_q <= 4'h0;
      end
      else if (BUS_IDLE && wdt_step_q != wdt_set_q)
      begin
         if (wdt_pre_q == WDT_STEP_CYC - 17'h1)
         begin
            wdt_pre_q  <= 17'h0;
            wdt_step_q <= wdt_step_q + 4'h1;
         end
         else
            wdt_pre_q <= wdt_pre_q + 17'h1;
      end
   end

   always @*
   begin
      state_d = state_q;
      case (state_q)
         `LFFR_S_POR:
            state_d = `LFFR_S_INIT;
         `LFFR_S_INIT:
            state_d = `LFFR_S_NORMAL;
         `LFFR_S_NORMAL:
            if (wdt_ovf)
               state_d = `LFFR_S_FAILSAFE;
         `LFFR_S_FAILSAFE:
            if (fs_clr_q)
               state_d = `LFFR_S_NORMAL;
         default:
            state_d = `LFFR_S_POR;
      endcase
      if (rail_s)
         state_d = `LFFR_S_POR;
   end

   always @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
         state_q <= `LFFR_S_POR;
      else
         state_q <= state_d;
   end

   // Command bits are one-cycle pulses, so they read back as zero after.
   always @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
      begin
         clr_q     <= 1'b0;
         fs_clr_q  <= 1'b0;
         por_clr_q <= 1'b0;
         sls_en_q  <= 1'b0;
         wdt_set_q <= `LFFR_RST_WDT;
         blank_q   <= `LFFR_RST_BLANK;
         mask_q    <= 9'h0;
         chen_q    <= 24'h0;
         diag_q    <= `LFFR_RST_DIAGEN;
         crc_q     <= `LFFR_RST_CRC;
      end
      else
      begin
         clr_q     <= wr_ctrl && WDATA[`LFFR_CTRL_CLR];
         fs_clr_q  <= wr_ctrl && WDATA[`LFFR_CTRL_FSCLR];
         por_clr_q <= wr_ctrl && WDATA[`LFFR_CTRL_PORCLR];
         if (wr_ctrl)
         begin
            sls_en_q  <= WDATA[`LFFR_CTRL_SINGLE_SHORT_ENABLE];
            wdt_set_q <= WDATA[`LFFR_CTRL_WDT_LSB +: 4];
            blank_q   <= WDATA[`LFFR_CTRL_BLK_LSB +: 8];
         end
         if (WR && ADDR == `LFFR_A_MASK)
            mask_q <= WDATA[8:0];
         if (WR && ADDR == `LFFR_A_CHEN)
            chen_q <= WDATA[23:0];
         if (WR && ADDR == `LFFR_A_DIAGEN)
            diag_q <= WDATA[23:0];
         if (WR && ADDR == `LFFR_A_CRC)
            crc_q <= WDATA[7:0];
      end
   end

   always @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
         rdata_q <= 32'h0;
      else if (RD)
      begin
         case (ADDR)
            `LFFR_A_CTRL:
               rdata_q <= {16'h0, blank_q, wdt_set_q, sls_en_q,
                           por_clr_q, fs_clr_q, clr_q};
            `LFFR_A_STATUS:
               rdata_q <= {22'h0, fs_q, por_q, gflag, out_q, st_q};
            `LFFR_A_MASK:
               rdata_q <= {23'h0, mask_q};
            `LFFR_A_CHEN:
               rdata_q <= {8'h0, chen_q};
            `LFFR_A_DIAGEN:
               rdata_q <= {8'h0, diag_q};
            `LFFR_A_OPEN:
               rdata_q <= {8'h0, open_q};
            `LFFR_A_SHORT:
               rdata_q <= {8'h0, short_q};
            `LFFR_A_SLS:
               rdata_q <= {8'h0, sls_q};
            `LFFR_A_STATE:
               rdata_q <= {24'h0, wdt_step_q, pin_s, OUTPUTS_OFF, state_q};
            `LFFR_A_CRC:
               rdata_q <= {16'h0, COMPUTED_CONFIG_CRC, crc_q};
            default:
               rdata_q <= 32'h0;
         endcase
      end
   end

   assign RDATA = rdata_q;
endmodule
`default_nettype wire

/* File: verif/lffr_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module lffr_host_model (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic hold_busy,
   input  wire logic kicking,
   input  wire logic pin_o,
   input  wire logic pin_oe_n,
   output wire logic bus_idle,
   output logic      xfer_ok,
   output wire logic pin_level
);
   logic [3:0] gap_q;
   assign bus_idle = ~hold_busy;
   // The fault line is open drain with a pull-up, so it reads high when released.
   assign pin_level = pin_oe_n ? 1'b1 : pin_o;
   // A good addressed transfer every fifteen cycles keeps the watchdog fed.
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         gap_q <= 4'h0;
         xfer_ok <= 1'b0;
      end
      else
      begin
         gap_q <= (gap_q == 4'he) ? 4'h0 : gap_q + 4'h1;
         xfer_ok <= kicking && (gap_q == 4'he);
      end
   end
endmodule
`default_nettype wire

/* File: verif/lffr_top_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
module lffr_top_chk (
   input wire logic        CORE_CLK,
   input wire logic        RST,
   input wire logic        WR,
   input wire logic        SUPPLY_UV_DET,
   input wire logic        THERMAL_DET,
   input wire logic        LOW_SUPPLY_DET,
   input wire logic        RAIL_FAULT_DET,
   input wire logic        IRQ,
   input wire logic        FAULT_PIN_OE_N,
   input wire logic        OUTPUTS_OFF,
   input wire logic        DETECT_HOLD,
   input wire logic [23:0] CHAN_OUT_EN,
   input wire logic [1:0]  DEV_STATE
);
   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (RST);

   AST_OUT_GATE: assert property (OUTPUTS_OFF |-> CHAN_OUT_EN == 24'h0)
      else $error("channel outputs on while switched off");
   AST_UV_OFF: assert property (SUPPLY_UV_DET [*3] |-> OUTPUTS_OFF)
      else $error("undervoltage did not switch outputs off");
   AST_TH_OFF: assert property (THERMAL_DET [*3] |-> OUTPUTS_OFF)
      else $error("overtemperature did not switch outputs off");
   AST_LS_HOLD: assert property (LOW_SUPPLY_DET [*3] |-> DETECT_HOLD)
      else $error("low supply did not hold detections");
   AST_POR_PIN: assert property (DEV_STATE == 2'h0 |-> !FAULT_PIN_OE_N && OUTPUTS_OFF)
      else $error("restart state without pin pull or outputs off");
   AST_RAIL_POR: assert property (RAIL_FAULT_DET [*4] |-> DEV_STATE == 2'h0)
      else $error("rail fault did not force restart state");
   AST_POR_INIT: assert property ((!RAIL_FAULT_DET [*3]) ##0 DEV_STATE == 2'h0 |=> DEV_STATE == 2'h1)
      else $error("good rails did not lead to initialization");
   AST_INIT_IRQ: assert property (DEV_STATE == 2'h1 |-> ##[0:1] IRQ)
      else $error("power-on flag not reported after restart");
   AST_FS_STAY: assert property (DEV_STATE == 2'h3 && !WR && !$past(WR) |=> DEV_STATE != 2'h2)
      else $error("fail-safe left without a clear");

   COV_FS: cover property (DEV_STATE == 2'h3);
   COV_PULL: cover property ($fell(FAULT_PIN_OE_N) && DEV_STATE == 2'h2);
   COV_OFF: cover property (OUTPUTS_OFF && DEV_STATE == 2'h2);
endmodule

bind lffr_top lffr_top_chk lffr_top_chk_i (
   .CORE_CLK      (CORE_CLK),
   .RST           (RST),
   .WR            (WR),
   .SUPPLY_UV_DET (SUPPLY_UV_DET),
   .THERMAL_DET   (THERMAL_DET),
   .LOW_SUPPLY_DET(LOW_SUPPLY_DET),
   .RAIL_FAULT_DET(RAIL_FAULT_DET),
   .IRQ           (IRQ),
   .FAULT_PIN_OE_N(FAULT_PIN_OE_N),
   .OUTPUTS_OFF   (OUTPUTS_OFF),
   .DETECT_HOLD   (DETECT_HOLD),
   .CHAN_OUT_EN   (CHAN_OUT_EN),
   .DEV_STATE     (DEV_STATE)
);
`default_nettype wire

/* File: verif/lffr_top_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "lffr_regs.vh"
module lffr_top_tb_top;
   logic        clk, rst, wr, rd, rail, cdone, busy, kick;
   logic [7:0]  addr, ccrc;
   logic [31:0] wdata;
   logic [23:0] opn, sht, sls, pwm;
   logic [5:0]  src;
   wire  [31:0] rdata;
   wire  [23:0] out_en;
   wire  [1:0]  st;
   wire         irq, pin_o, pin_oe_n, pin_i, outs_off, det_hold, bus_idle, xfer_ok;
   integer      bad_count, total_checks, seed, i, m, t, c, c1, ch;

   lffr_top #(.PULSE_CYC(13'h14), .WDT_STEP_CYC(17'ha)) lffr_top_i (
      .CORE_CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
      .RDATA(rdata), .IRQ(irq), .CHAN_OPEN_DET(opn), .CHAN_SHORT_DET(sht),
      .CHAN_SLS_DET(sls), .PWM_ON(pwm), .LOW_SUPPLY_DET(src[0]), .SUPPLY_UV_DET(src[1]),
      .REF_FAULT_DET(src[2]), .PRETHERMAL_DET(src[3]), .THERMAL_DET(src[4]),
      .RAIL_FAULT_DET(rail), .COMPUTED_CONFIG_CRC(ccrc), .CRC_CHECK_DONE(cdone),
      .BUS_IDLE(bus_idle), .XFER_OK(xfer_ok), .FAULT_PIN_I(pin_i), .FAULT_PIN_O(pin_o),
      .FAULT_PIN_OE_N(pin_oe_n), .OUTPUTS_OFF(outs_off), .DETECT_HOLD(det_hold),
      .CHAN_OUT_EN(out_en), .DEV_STATE(st));

   lffr_host_model lffr_host_model_i (
      .clk(clk), .rst(rst), .hold_busy(busy), .kicking(kick), .pin_o(pin_o),
      .pin_oe_n(pin_oe_n), .bus_idle(bus_idle), .xfer_ok(xfer_ok), .pin_level(pin_i));

   task end_of_test;
      begin
         $display("checks %0d mismatches %0d", total_checks, bad_count);
         if (bad_count == 0 && total_checks > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      begin
         total_checks = total_checks + 1;
         if (got !== exp)
         begin
            bad_count = bad_count + 1;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask

   task wr_reg(input logic [7:0] a, input logic [31:0] d);
      begin
         @(posedge clk);
         addr <= a;
         wdata <= d;
         wr <= 1'b1;
         @(posedge clk);
         wr <= 1'b0;
      end
   endtask

   task rd_reg(input logic [7:0] a, input logic [31:0] exp);
      begin
         @(posedge clk);
         addr <= a;
         rd <= 1'b1;
         @(posedge clk);
         rd <= 1'b0;
         #1;
         chk(rdata, exp);
      end
   endtask

   // Counts the cycles in which the fault pin is pulled low.
   task low(input integer n);
      begin
         c = 0;
         repeat (n)
         begin
            @(posedge clk);
            #1;
            if (pin_oe_n === 1'b0)
               c = c + 1;
         end
      end
   endtask

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   initial
   begin
      repeat (40000) @(posedge clk);
      bad_count = bad_count + 1;
      end_of_test;
   end

   initial
   begin
      seed = 22371;
      bad_count = 0;
      total_checks = 0;
      {rst, wr, rd, rail, cdone, busy, kick} = 7'h40;
      {addr, ccrc, wdata, src} = 54'h0;
      {opn, sht, sls, pwm} = 96'h0;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      low(4);
      rd_reg(`LFFR_A_STATUS, 32'h180);
      rd_reg(`LFFR_A_CTRL, 32'h1000);
      rd_reg(`LFFR_A_DIAGEN, 32'hffffff);
      rd_reg(`LFFR_A_CRC, 32'hff);
      rd_reg(8'h30, 32'h0);
      wr_reg(`LFFR_A_CTRL, 32'h1004);
      low(2);
      rd_reg(`LFFR_A_STATUS, 32'h0);
      for (i = 0; i < 6; i = i + 1)
         for (m = 0; m < 2; m = m + 1)
         begin
            wr_reg(`LFFR_A_MASK, m << i);
            src[i] <= (i < 5);
            ccrc <= 8'h5a;
            cdone <= (i == 5);
            low(6);
            cdone <= 1'b0;
            c1 = c;
            low(34);
            if (i == 1 || i == 2 || i == 4)
               chk(c, m ? 0 : 34);
            else
               chk(c + c1, m ? 0 : 20);
            chk(outs_off, i == 1 || i == 4);
            chk(det_hold, i == 0);
            chk(irq, !m);
            src <= 6'h0;
            low(6);
            chk(pin_oe_n, 1'b1);
            chk(outs_off, 1'b0);
            rd_reg(`LFFR_A_STATUS, (32'h1 << i) | ((1 - m) << 7));
            // Masked passes clear their flag by writing one to it, the others by fault clear.
            wr_reg(m ? `LFFR_A_STATUS : `LFFR_A_CTRL, m ? (32'h1 << i) : 32'h1001);
            low(2);
            rd_reg(`LFFR_A_STATUS, 32'h0);
            rd_reg(`LFFR_A_CTRL, 32'h1000);
         end
      ch = {$random(seed)} % 24;
      pwm <= 24'hffffff;
      wr_reg(`LFFR_A_CHEN, 32'h1 << ch);
      wr_reg(`LFFR_A_CTRL, 32'h108);
      #1;
      chk(out_en, 32'h1 << ch);
      for (t = 0; t < 3; t = t + 1)
         for (m = 0; m < 3; m = m + 1)
         begin
            wr_reg(`LFFR_A_DIAGEN, m == 2 ? 32'h0 : 32'hffffff);
            wr_reg(`LFFR_A_MASK, m == 1 ? 32'h40 << t : 32'h0);
            {sls, sht, opn} <= 72'h1 << (24 * t + ch);
            low(700);
            chk(c, m == 0 ? 20 : 0);
            rd_reg(8'(`LFFR_A_OPEN + 4 * t), m == 2 ? 32'h0 : 32'h1 << ch);
            rd_reg(`LFFR_A_STATUS, m == 0 ? 32'hc0 : 32'h0);
            {sls, sht, opn} <= 72'h0;
            wr_reg(`LFFR_A_CTRL, 32'h109);
            low(2);
            rd_reg(8'(`LFFR_A_OPEN + 4 * t), 32'h0);
         end
      rail <= 1'b1;
      low(8);
      chk(st, 2'h0);
      chk(pin_oe_n, 1'b0);
      chk(pin_o, 1'b0);
      rd_reg(`LFFR_A_STATE, 32'h4);
      rail <= 1'b0;
      low(8);
      chk(st, 2'h2);
      rd_reg(`LFFR_A_STATUS, 32'h180);
      wr_reg(`LFFR_A_CTRL, 32'h1004);
      wr_reg(`LFFR_A_CTRL, 32'h10f0);
      low(3);
      chk(st, 2'h3);
      chk(c, 0);
      rd_reg(`LFFR_A_STATUS, 32'h200);
      wr_reg(`LFFR_A_CTRL, 32'h1002);
      low(3);
      chk(st, 2'h2);
      kick <= 1'b1;
      wr_reg(`LFFR_A_CTRL, 32'h1020);
      low(80);
      chk(st, 2'h2);
      kick <= 1'b0;
      busy <= 1'b1;
      low(80);
      chk(st, 2'h2);
      busy <= 1'b0;
      low(30);
      chk(st, 2'h3);
      wr_reg(`LFFR_A_CTRL, 32'h1002);
      low(3);
      chk(st, 2'h2);
      rd_reg(`LFFR_A_STATE, 32'ha);
      end_of_test;
   end
endmodule
`default_nettype wire
